// [asrp_host_model.sv]
// host controller model driving the port pins, mode 0 framing
`timescale 1ns/1ps
module asrp_host_model #(
  parameter int HALF = 5
) (
  // clock
  input wire logic sys_clk,
  // host pins
  output logic     cs_n,
  output logic     sclk,
  output logic     sdi,
  output logic     conversion_trigger
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b1;
    conversion_trigger = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : hold
  // one device, one select at a time; always a full 20-edge word
  task automatic frame(input logic [19:0] word, input int tail);
    hold(1);
    cs_n = 1'b0;
    hold(6);
    for (int i = 19; i >= 0; i--) begin
      sdi = word[i];
      hold(HALF);
      sclk = 1'b1;
      hold(HALF);
      sclk = 1'b0;
    end
    hold(tail);
    // released line must not keep showing the last bit
    sdi = ~sdi;
    cs_n = 1'b1;
    hold(8);
  endtask : frame
  // trigger driven on its own, not tied to select
  task automatic pulse;
    conversion_trigger = 1'b1;
    hold(10);
    conversion_trigger = 1'b0;
    hold(10);
  endtask : pulse
endmodule : asrp_host_model

// [asrp_pkg.sv]
// shared constants and types for the adc serial readout port
package asrp_pkg;

  // word and lane geometry
  localparam int ASRP_WORD_W     = 20;
  localparam int ASRP_LANES      = 4;
  localparam int ASRP_FIFO_DEPTH = 16;

  // output protocol register layout, bit 7 down to bit 0
  typedef struct packed {
    logic [1:0] clk_sel;
    logic       rsvd;
    logic       ddr;
    logic [1:0] lanes;
    logic [1:0] mode;
  } asrp_out_cfg_t;

  // frame word decoded when chip select rises
  typedef struct packed {
    logic [3:0] cmd;
    logic [7:0] index;
    logic [7:0] data;
  } asrp_cmd_t;

  // reset values
  localparam logic [7:0] ASRP_OUT_CFG_RST = 8'h00;
  localparam logic [1:0] ASRP_IN_MODE_RST = 2'h0;

  // output protocol field codes
  localparam logic [1:0] ASRP_MODE_FOLLOW = 2'h0;
  localparam logic [1:0] ASRP_MODE_SRC    = 2'h3;

  // output lane count codes
  localparam logic [1:0] ASRP_LANES_DUAL = 2'h2;
  localparam logic [1:0] ASRP_LANES_QUAD = 2'h3;

  // forwarded clock source codes
  typedef enum logic [1:0] {
    ASRP_CLK_ECHO = 2'h0,
    ASRP_CLK_INT  = 2'h1,
    ASRP_CLK_DIV2 = 2'h2,
    ASRP_CLK_DIV4 = 2'h3
  } asrp_clk_sel_t;

  // strobe half-period in sys_clk cycles, minus one
  localparam logic [1:0] ASRP_TICK_INT  = 2'h0;
  localparam logic [1:0] ASRP_TICK_DIV2 = 2'h1;
  localparam logic [1:0] ASRP_TICK_DIV4 = 2'h3;

  // launches per 20-bit word
  localparam logic [4:0] ASRP_LAUNCH_SINGLE = 5'h14;
  localparam logic [4:0] ASRP_LAUNCH_DUAL   = 5'h0A;
  localparam logic [4:0] ASRP_LAUNCH_QUAD   = 5'h05;

  // configuration write command and register indices
  localparam logic [3:0] ASRP_CMD_WRITE = 4'h1;
  localparam logic [7:0] ASRP_IDX_IN    = 8'h14;
  localparam logic [7:0] ASRP_IDX_OUT   = 8'h18;

  // pin synchroniser slots and idle levels
  localparam int         ASRP_PIN_CS   = 0;
  localparam int         ASRP_PIN_SCLK = 1;
  localparam int         ASRP_PIN_SDI  = 2;
  localparam int         ASRP_PIN_TRIG = 3;
  localparam logic [3:0] ASRP_PIN_IDLE = 4'h1;

  // frame state machine
  typedef enum logic [1:0] {
    ASRP_ST_IDLE  = 2'b01,
    ASRP_ST_FRAME = 2'b10
  } asrp_state_t;

endpackage : asrp_pkg

// [asrp_port.sv]
// serial readout port: result fifo and the pin-side shift logic
`timescale 1ns/1ps

// Summary of operation
// - forwarded readout uses one output lane unless lane count widens it
// - dual lane count launches two bits per edge on lanes 0 and 1
// - quad lane count launches four bits per edge on lanes 0 to 3
// - single rate launches bits only on rising strobe edges
// - double rate toggles strobe, launches every edge, first edge rising
// - every clock source, lane count and rate combination works
// - chained mode merges in and out shifters into one 20-bit chain
// - analog sampling happens on the trigger rising edge
// - a frame starts on the chip select falling edge
// - each launch edge drives the chain msb onto lane 0
// - each capture edge shifts serial input into the chain lsb in chained mode, into rx_q otherwise
// - chip select rising decodes the chain, or rx_q in wide and forwarded modes, and acts on it
// - forwarded readout drives its clock on the strobe pin
// - output field 11b forwards clock, 00b follows input, others unused
// - clock source codes echo, internal, internal/2, internal/4
// - reset restores polarity 0, phase 0 protocol for reads and writes

module asrp_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;

  assign push     = in_valid & in_ready;
  assign pop      = out_valid & out_ready;
  assign cnt_d    = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  assign out_data = mem[rd_q];

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // flags registered so ready and valid come straight from flip-flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q      <= '0;
      rd_q      <= '0;
      cnt_q     <= '0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      wr_q      <= push ? AW'(wr_q + 1'b1) : wr_q;
      rd_q      <= pop ? AW'(rd_q + 1'b1) : rd_q;
      cnt_q     <= cnt_d;
      in_ready  <= cnt_d != FULL;
      out_valid <= cnt_d != '0;
    end
  end
endmodule : asrp_fifo

module asrp_port #(
  parameter int WORD_W = 20,
  parameter int DEPTH  = 16
) (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  // host pins
  input  wire logic                  cs_n,
  input  wire logic                  sclk,
  input  wire logic                  sdi,
  input  wire logic                  conversion_trigger,
  output logic                 [3:0] sdo_q,
  output logic                 [3:0] sdo_oe_q,
  output logic                       strobe_pin_q,
  // conversion results from the converter core
  input  wire logic                  result_valid,
  output logic                       result_ready,
  input  wire logic     [WORD_W-1:0] result_data,
  output logic                       sample_pulse_q,
  // decoded frame and configuration
  output asrp_pkg::asrp_cmd_t        frame_word_q,
  output logic                       frame_word_valid_q,
  output logic                 [7:0] frame_edges_q,
  output logic                 [1:0] input_protocol_q,
  output asrp_pkg::asrp_out_cfg_t    output_protocol_q
);
  import asrp_pkg::*;

  // pin synchronisers
  logic [3:0] pin_in;
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [3:0] s3_q;
  logic [3:0] lvl_q;
  logic [3:0] lvl_d;

  assign pin_in = {conversion_trigger, sdi, sclk, cs_n};

  genvar g;
  for (g = 0; g < 4; g++) begin : g_sync
    // change accepted only when stages two and three agree
    assign lvl_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : lvl_q[g];
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        s1_q[g]  <= ASRP_PIN_IDLE[g];
        s2_q[g]  <= ASRP_PIN_IDLE[g];
        s3_q[g]  <= ASRP_PIN_IDLE[g];
        lvl_q[g] <= ASRP_PIN_IDLE[g];
      end else begin
        s1_q[g]  <= pin_in[g];
        s2_q[g]  <= s1_q[g];
        s3_q[g]  <= s2_q[g];
        lvl_q[g] <= lvl_d[g];
      end
    end
  end

  // edge decode
  wire cs_fall   = lvl_q[ASRP_PIN_CS] & ~lvl_d[ASRP_PIN_CS];
  wire cs_rise   = ~lvl_q[ASRP_PIN_CS] & lvl_d[ASRP_PIN_CS];
  wire sclk_rise = ~lvl_q[ASRP_PIN_SCLK] & lvl_d[ASRP_PIN_SCLK];
  wire sclk_fall = lvl_q[ASRP_PIN_SCLK] & ~lvl_d[ASRP_PIN_SCLK];
  wire trig_rise = ~lvl_q[ASRP_PIN_TRIG] & lvl_d[ASRP_PIN_TRIG];
  wire sdi_lvl   = lvl_d[ASRP_PIN_SDI];

  // state and configuration
  asrp_state_t   state_q;
  asrp_state_t   state_d;
  asrp_out_cfg_t ocfg;
  asrp_clk_sel_t clk_sel;
  logic          active;

  assign ocfg    = output_protocol_q;
  assign clk_sel = asrp_clk_sel_t'(ocfg.clk_sel);
  assign active  = state_q == ASRP_ST_FRAME;

  wire cpol      = input_protocol_q[1];
  wire cpha      = input_protocol_q[0];
  wire mode_src  = ocfg.mode == ASRP_MODE_SRC;
  wire mode_leg  = ocfg.mode == ASRP_MODE_FOLLOW;
  wire mode_bad  = ~mode_src & ~mode_leg;
  wire wide      = ocfg.lanes[1];
  wire shift_w   = mode_src | wide;
  // mode 0 and 3 capture on rising sclk, modes 1 and 2 on falling
  wire cap_rise  = ~(cpol ^ cpha);
  // sdi follows the input protocol whatever the output mode
  wire capture   = active & (cap_rise ? sclk_rise : sclk_fall);
  wire leg_launch = active & mode_leg & (cap_rise ? sclk_fall : sclk_rise);

  // lane selection, lane 0 always carries the earliest bit
  function automatic logic [3:0] top_bits(input logic [WORD_W-1:0] v,
                                          input logic [1:0] lanes);
    logic [3:0] r;
    r = {3'h0, v[WORD_W-1]};
    if (lanes == ASRP_LANES_QUAD) begin
      r = {v[WORD_W-4], v[WORD_W-3], v[WORD_W-2], v[WORD_W-1]};
    end else if (lanes == ASRP_LANES_DUAL) begin
      r = {2'h0, v[WORD_W-2], v[WORD_W-1]};
    end
    return r;
  endfunction : top_bits

  function automatic logic [WORD_W-1:0] drop_bits(
      input logic [WORD_W-1:0] v, input logic [1:0] lanes);
    logic [WORD_W-1:0] r;
    r = {v[WORD_W-2:0], 1'b0};
    if (lanes == ASRP_LANES_QUAD) begin
      r = {v[WORD_W-5:0], 4'h0};
    end else if (lanes == ASRP_LANES_DUAL) begin
      r = {v[WORD_W-3:0], 2'h0};
    end
    return r;
  endfunction : drop_bits

  // result fifo, drained one word per frame start
  logic              fifo_valid;
  logic [WORD_W-1:0] fifo_data;

  asrp_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (result_valid),
    .in_ready  (result_ready),
    .in_data   (result_data),
    .out_valid (fifo_valid),
    .out_ready (cs_fall),
    .out_data  (fifo_data)
  );

  // an empty fifo at frame start shifts out zeros rather than stale data
  wire [WORD_W-1:0] load_word = fifo_valid ? fifo_data : '0;

  // forwarded clock generation
  logic [1:0] div_q;
  logic [1:0] tick_lim;
  logic [4:0] left_q;
  logic [4:0] launch_cnt;

  assign tick_lim = (clk_sel == ASRP_CLK_DIV4) ? ASRP_TICK_DIV4 :
                    (clk_sel == ASRP_CLK_DIV2) ? ASRP_TICK_DIV2 :
                    ASRP_TICK_INT;
  assign launch_cnt = (ocfg.lanes == ASRP_LANES_QUAD) ? ASRP_LAUNCH_QUAD :
                      (ocfg.lanes == ASRP_LANES_DUAL) ? ASRP_LAUNCH_DUAL :
                      ASRP_LAUNCH_SINGLE;

  wire tick      = div_q == tick_lim;
  wire echo_edge = sclk_rise | sclk_fall;
  wire src_run   = active & mode_src & ((left_q != '0) | strobe_pin_q);
  wire strobe_ev = src_run & ((clk_sel == ASRP_CLK_ECHO) ? echo_edge : tick);
  wire src_launch = strobe_ev & (left_q != '0) & (ocfg.ddr | ~strobe_pin_q);
  wire launch     = mode_src ? src_launch : leg_launch;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 2'h0;
    end else begin
      div_q <= (src_run & ~tick) ? 2'(div_q + 2'h1) : 2'h0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      left_q <= 5'h00;
    end else if (cs_fall) begin
      left_q <= launch_cnt;
    end else if (src_launch) begin
      left_q <= 5'(left_q - 5'h01);
    end
  end

  // strobe stays low outside source-synchronous frames
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_pin_q <= 1'b0;
    end else if (!active || cs_rise) begin
      strobe_pin_q <= 1'b0;
    end else if (strobe_ev) begin
      strobe_pin_q <= ~strobe_pin_q;
    end
  end

  // unified shift chain and lane drivers
  logic [WORD_W-1:0] chain_q;
  logic [WORD_W-1:0] chain_d;
  logic [3:0]        sdo_d;

  always_comb begin
    chain_d = chain_q;
    sdo_d   = sdo_q;
    if (cs_fall) begin
      chain_d = load_word;
      // phase 0 legacy frames show the msb from the falling chip select
      if (mode_leg && !cpha) begin
        sdo_d = top_bits(load_word, ocfg.lanes);
        if (wide) begin
          chain_d = drop_bits(load_word, ocfg.lanes);
        end
      end
    end else if (active) begin
      if (launch) begin
        sdo_d = top_bits(chain_q, ocfg.lanes);
        if (shift_w) begin
          chain_d = drop_bits(chain_q, ocfg.lanes);
        end
      end
      if (capture && !shift_w) begin
        chain_d = {chain_q[WORD_W-2:0], sdi_lvl};
      end
    end
  end

  // lanes released whenever chip select is high, so star wiring can share
  wire [3:0] lane_mask = (ocfg.lanes == ASRP_LANES_QUAD) ? 4'hF :
                         (ocfg.lanes == ASRP_LANES_DUAL) ? 4'h3 : 4'h1;
  wire       drive_d   = (state_d == ASRP_ST_FRAME) & ~mode_bad;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      chain_q  <= '0;
      sdo_q    <= 4'h0;
      sdo_oe_q <= 4'h0;
    end else begin
      chain_q  <= chain_d;
      sdo_q    <= sdo_d;
      sdo_oe_q <= drive_d ? lane_mask : 4'h0;
    end
  end

  // frame state machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      ASRP_ST_IDLE: begin
        if (cs_fall) begin
          state_d = ASRP_ST_FRAME;
        end
      end
      ASRP_ST_FRAME: begin
        if (cs_rise) begin
          state_d = ASRP_ST_IDLE;
        end
      end
      default: begin
        state_d = ASRP_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ASRP_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // capture edge count, saturating, shown with each decoded word
  logic [7:0] edges_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      edges_q <= 8'h00;
    end else if (cs_fall) begin
      edges_q <= 8'h00;
    end else if (capture && edges_q != 8'hFF) begin
      edges_q <= 8'(edges_q + 8'h01);
    end
  end

  // own input shifter for wide and forwarded modes, where the chain is
  // busy shifting results out and cannot take sdi as well
  logic [WORD_W-1:0] rx_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_q <= '0;
    end else if (capture) begin
      rx_q <= {rx_q[WORD_W-2:0], sdi_lvl};
    end
  end

  // decode at chip select rise; short frames still decode what they hold
  asrp_cmd_t chain_cmd;
  assign chain_cmd = asrp_cmd_t'(shift_w ? rx_q : chain_q);

  wire wr_cmd = cs_rise & active & (chain_cmd.cmd == ASRP_CMD_WRITE);
  wire wr_in  = wr_cmd & (chain_cmd.index == ASRP_IDX_IN);
  wire wr_out = wr_cmd & (chain_cmd.index == ASRP_IDX_OUT);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_word_q       <= '0;
      frame_word_valid_q <= 1'b0;
      frame_edges_q      <= 8'h00;
    end else begin
      frame_word_valid_q <= cs_rise & active;
      if (cs_rise && active) begin
        frame_word_q  <= chain_cmd;
        frame_edges_q <= edges_q;
      end
    end
  end

  // configuration; reserved bit 5 always reads zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      input_protocol_q  <= ASRP_IN_MODE_RST;
      output_protocol_q <= asrp_out_cfg_t'(ASRP_OUT_CFG_RST);
    end else begin
      if (wr_in) begin
        input_protocol_q <= chain_cmd.data[1:0];
      end
      if (wr_out) begin
        output_protocol_q      <= asrp_out_cfg_t'(chain_cmd.data);
        output_protocol_q.rsvd <= 1'b0;
      end
    end
  end

  // sample request to the converter core
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_pulse_q <= 1'b0;
    end else begin
      sample_pulse_q <= trig_rise;
    end
  end

endmodule : asrp_port

// [asrp_port_bench.sv]
// self-checking bench for the readout port
`timescale 1ns/1ps
module asrp_port_bench;
  import asrp_pkg::*;
  logic          sys_clk;
  logic          rst_n;
  logic          result_valid;
  logic   [19:0] result_data;
  wire           cs_n, sclk, sdi, conversion_trigger;
  wire     [3:0] sdo_q, sdo_oe_q;
  wire           strobe_pin_q, result_ready, sample_pulse_q;
  wire           frame_word_valid_q;
  wire asrp_cmd_t frame_word_q;
  wire     [7:0] frame_edges_q;
  wire     [1:0] input_protocol_q;
  wire asrp_out_cfg_t output_protocol_q;
  int            miscompares, compares, cycles, rises, pulses, ncap, need;
  logic   [19:0] cap, exp;
  logic    [3:0] oe_seen;
  logic    [1:0] cap_mode;
  logic   [19:0] words[$];
  logic    [7:0] cfg[8] = '{8'h43, 8'h53, 8'h8B, 8'hCF,
                            8'hD3, 8'h9B, 8'h5F, 8'h01};

  asrp_host_model host (.sys_clk(sys_clk), .cs_n(cs_n), .sclk(sclk),
    .sdi(sdi), .conversion_trigger(conversion_trigger));
  asrp_port uut (.sys_clk(sys_clk), .rst_n(rst_n), .cs_n(cs_n),
    .sclk(sclk), .sdi(sdi), .conversion_trigger(conversion_trigger),
    .sdo_q(sdo_q), .sdo_oe_q(sdo_oe_q), .strobe_pin_q(strobe_pin_q),
    .result_valid(result_valid), .result_ready(result_ready),
    .result_data(result_data), .sample_pulse_q(sample_pulse_q),
    .frame_word_q(frame_word_q), .frame_word_valid_q(frame_word_valid_q),
    .frame_edges_q(frame_edges_q), .input_protocol_q(input_protocol_q),
    .output_protocol_q(output_protocol_q));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // host samples on sclk rise in mode 0, on strobe fall in forwarded sdr
  always @(posedge sclk) begin
    oe_seen = sdo_oe_q;
    if (cap_mode == 2'h0 && ncap < need) cap = {cap[18:0], sdo_q[0]};
    if (cap_mode == 2'h1 && ncap < need) cap = {cap[17:0], sdo_q[0], sdo_q[1]};
    if (cap_mode != 2'h2) ncap++;
  end
  always @(negedge strobe_pin_q) begin
    // lane 0 carries the earliest bit of each launch
    if (cap_mode == 2'h2 && ncap < need)
      cap = {cap[15:0], sdo_q[0], sdo_q[1], sdo_q[2], sdo_q[3]};
    if (cap_mode == 2'h2) ncap++;
  end
  always @(posedge strobe_pin_q) rises++;
  always @(posedge sys_clk) begin
    if (sample_pulse_q === 1'b1) pulses++;
    cycles++;
    if (cycles == 12000) begin
      miscompares++;
      final_report();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] want);
    compares++;
    if (got !== want) begin
      miscompares++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, want);
    end
  endtask : check
  task automatic final_report;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  // each frame pops one result and writes one configuration word
  task automatic run(input logic [7:0] idx, input logic [7:0] val,
                     input int tail, input logic [1:0] m, input int n);
    exp = (words.size() > 0) ? words.pop_front() : 20'h00000;
    cap = 20'h00000;
    cap_mode = m;
    need = n;
    ncap = 0;
    rises = 0;
    oe_seen = 4'h0;
    host.frame({ASRP_CMD_WRITE, idx, val}, tail);
  endtask : run

  task automatic t_fill;
    logic rdy;
    rdy = 1'b0;
    for (int i = 0; i < 18; i++) begin
      @(negedge sys_clk);
      // taken only if ready stood at the edge that followed the offer
      if (rdy === 1'b1) words.push_back(result_data);
      rdy = result_ready;
      result_valid = 1'b1;
      result_data = 20'(20'hA5000 + i * 20'h00F13);
    end
    @(negedge sys_clk);
    if (rdy === 1'b1) words.push_back(result_data);
    result_valid = 1'b0;
    check(words.size(), 16);
    check(result_ready, 1'b0);
    $display("fill test done");
  endtask : t_fill
  task automatic t_legacy;
    check(output_protocol_q, 8'h00);
    check(input_protocol_q, 2'h0);
    run(ASRP_IDX_OUT, 8'h08, 2, 2'h0, 20);
    check(cap, exp);
    check(frame_word_q, {ASRP_CMD_WRITE, ASRP_IDX_OUT, 8'h08});
    check(frame_edges_q, 8'h14);
    check(oe_seen, 4'h1);
    check(output_protocol_q, 8'h08);
    check(result_ready, 1'b1);
    $display("legacy test done");
  endtask : t_legacy
  task automatic t_wide;
    run(ASRP_IDX_OUT, 8'h0F, 2, 2'h1, 10);
    check(cap, exp);
    check(oe_seen, 4'h3);
    run(ASRP_IDX_OUT, cfg[0], 2, 2'h2, 5);
    check(cap, exp);
    check(oe_seen, 4'hF);
    $display("wide test done");
  endtask : t_wide
  task automatic t_forward;
    int l, ln;
    for (int i = 0; i < 7; i++) begin
      run(ASRP_IDX_OUT, cfg[i+1], 120, 2'h3, 0);
      l = (cfg[i][3:2] == 2'h3) ? 4 : (cfg[i][3:2] == 2'h2) ? 2 : 1;
      ln = 20 / l;
      check(rises, cfg[i][4] ? (ln + 1) / 2 : ln);
      check(oe_seen, (4'h1 << l) - 4'h1);
    end
    run(ASRP_IDX_OUT, 8'h20, 2, 2'h3, 0);
    check(oe_seen, 4'h0);
    check(output_protocol_q, 8'h00);
    run(ASRP_IDX_IN, 8'h01, 2, 2'h3, 0);
    check(input_protocol_q, 2'h1);
    $display("forward test done");
  endtask : t_forward
  task automatic t_trigger;
    pulses = 0;
    host.pulse();
    check(pulses, 1);
    $display("trigger test done");
  endtask : t_trigger

  initial begin
    rst_n = 1'b0;
    result_valid = 1'b0;
    result_data = 20'h00000;
    cap_mode = 2'h3;
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (5) @(negedge sys_clk);
    t_fill();
    t_legacy();
    t_wide();
    t_forward();
    t_trigger();
    final_report();
  end
endmodule : asrp_port_bench

// [asrp_port_sva.sv]
// checker for the readout port outputs
`timescale 1ns/1ps
module asrp_port_sva (
  // clock and reset
  input wire logic                    sys_clk,
  input wire logic                    rst_n,
  // host pins
  input wire logic                    cs_n,
  input wire logic                    conversion_trigger,
  input wire logic              [3:0] sdo_oe_q,
  input wire logic                    strobe_pin_q,
  // decoded outputs
  input wire logic                    sample_pulse_q,
  input wire asrp_pkg::asrp_cmd_t     frame_word_q,
  input wire logic                    frame_word_valid_q,
  input wire logic              [1:0] input_protocol_q,
  input wire asrp_pkg::asrp_out_cfg_t output_protocol_q
);
  import asrp_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire wr_q = frame_word_valid_q && frame_word_q.cmd == ASRP_CMD_WRITE;
  wire wr_out = wr_q && frame_word_q.index == ASRP_IDX_OUT;
  wire wr_in = wr_q && frame_word_q.index == ASRP_IDX_IN;
  // five cycles covers the three-stage synchroniser plus the register
  oe_idle_a: assert property (cs_n [*5] |-> sdo_oe_q == 4'h0)
    else $error("lanes driven outside a frame");
  legacy_strobe_a: assert property (
    output_protocol_q.mode == ASRP_MODE_FOLLOW |-> !strobe_pin_q)
    else $error("strobe moved in a legacy mode");
  bad_mode_a: assert property (
    ^output_protocol_q.mode |-> sdo_oe_q == 4'h0)
    else $error("lanes driven in an unsupported mode");
  single_lane_a: assert property (
    !output_protocol_q.lanes[1] |-> sdo_oe_q[3:1] == 3'h0)
    else $error("extra lanes driven in single mode");
  dual_lane_a: assert property (
    output_protocol_q.lanes == ASRP_LANES_DUAL |-> sdo_oe_q[3:2] == 2'h0)
    else $error("upper lanes driven in dual mode");
  trig_pulse_a: assert property (
    $rose(conversion_trigger) |-> ##[2:5] sample_pulse_q)
    else $error("trigger rise gave no sample pulse");
  pulse_once_a: assert property (sample_pulse_q |=> !sample_pulse_q)
    else $error("sample pulse longer than one cycle");
  cs_decode_a: assert property (
    $rose(cs_n) |-> ##[3:6] frame_word_valid_q)
    else $error("chip select rise gave no decode");
  word_once_a: assert property (
    frame_word_valid_q |=> !frame_word_valid_q)
    else $error("decode pulse longer than one cycle");
  out_cfg_a: assert property (wr_out |=>
    output_protocol_q == ($past(frame_word_q.data) & 8'hDF))
    else $error("output protocol write not applied");
  in_cfg_a: assert property (wr_in |=>
    input_protocol_q == $past(frame_word_q.data[1:0]))
    else $error("input protocol write not applied");
  cover property (wr_out);
  cover property (output_protocol_q.mode == ASRP_MODE_SRC && strobe_pin_q);
  cover property (sample_pulse_q);
endmodule : asrp_port_sva

bind asrp_port asrp_port_sva u_sva (
  .sys_clk            (sys_clk),
  .rst_n              (rst_n),
  .cs_n               (cs_n),
  .conversion_trigger (conversion_trigger),
  .sdo_oe_q           (sdo_oe_q),
  .strobe_pin_q       (strobe_pin_q),
  .sample_pulse_q     (sample_pulse_q),
  .frame_word_q       (frame_word_q),
  .frame_word_valid_q (frame_word_valid_q),
  .input_protocol_q   (input_protocol_q),
  .output_protocol_q  (output_protocol_q)
);
